// file: src/serial_config_pkg.sv
// Shared constants and types for the two-wire configuration port.
package serial_config_pkg;

    localparam int SYS_CLK_NS = 4;

    // Deglitch window on both bus lines, a least time rounded up.
    localparam int DEGLITCH_NS = 120;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int FILT_CNT_W = 5;
    localparam logic [FILT_CNT_W-1:0] FILT_LAST = FILT_CNT_W'(DEGLITCH_CYC - 1);

    // Host serial clock quarter period: over three deglitch windows, yet short enough
    // that a whole read stays under sixteen thousand system clocks long.
    localparam int SCL_QUARTER_NS = 400;
    localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int QCNT_W = 10;
    localparam logic [QCNT_W-1:0] QUARTER_LAST = QCNT_W'(SCL_QUARTER_CYC - 1);

    localparam int BUS_ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic DIR_READ = 1'b1;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic [1:0] LAST_QUARTER = 2'h3;
    localparam logic [1:0] SAMPLE_QUARTER = 2'h1;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_REG = 4'h3,
        ST_REG_ACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RDATA_ACK = 4'h8
    } slave_state_t;

    typedef enum logic [1:0] {
        STEP_START = 2'h0,
        STEP_BYTE = 2'h1,
        STEP_STOP = 2'h2,
        STEP_DONE = 2'h3
    } step_kind_t;

    // Host step numbers within a transaction.
    localparam logic [2:0] STEP_DEV_W = 3'h1;
    localparam logic [2:0] STEP_REG = 3'h2;
    localparam logic [2:0] STEP_DATA_OR_RESTART = 3'h3;
    localparam logic [2:0] STEP_DEV_R = 3'h4;
    localparam logic [2:0] STEP_RX = 3'h5;
    localparam logic [2:0] STEP_RD_STOP = 3'h6;
    localparam logic [2:0] STEP_WR_STOP = 3'h4;

endpackage

// file: src/serial_config_if.sv
// Two-wire bus between the host controller and the configuration slave.
`timescale 1ns/10ps
interface serial_config_if;
    logic scl;
    logic hostSdaOe;
    logic hostSdaOut;
    logic devSdaOe;
    logic devSdaOut;
    logic sda;

    // Open drain: the line is low whenever an enabled driver puts out a low.
    assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

    modport device (
        input scl,
        input sda,
        output devSdaOe,
        output devSdaOut
    );

    modport host (
        output scl,
        output hostSdaOe,
        output hostSdaOut,
        input sda
    );
endinterface

// file: src/line_deglitch.sv
// Synchroniser and stability filter for one bus line, with edge pulses.
`timescale 1ns/10ps
module line_deglitch (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic lineIn,
    output logic level,
    output logic rise,
    output logic fall
);
    logic syncA;
    logic syncB;
    logic [serial_config_pkg::FILT_CNT_W-1:0] stableCnt;
    logic flip;

    // The bus idles high, so the chain resets high to avoid a false edge.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA <= 1'b1;
            syncB <= 1'b1;
        end else begin
            syncA <= lineIn;
            syncB <= syncA;
        end
    end

    assign flip = (syncB != level) && (stableCnt == serial_config_pkg::FILT_LAST);

    // Pulses shorter than the window never reach the level.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stableCnt <= '0;
            level <= 1'b1;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= flip && syncB;
            fall <= flip && !syncB;
            if (syncB == level || flip) begin
                stableCnt <= '0;
            end else begin
                stableCnt <= stableCnt + 1'b1;
            end
            if (flip) begin
                level <= syncB;
            end
        end
    end
endmodule // line_deglitch

// file: src/serial_config_slave.sv
// Device end of the two-wire configuration port.
// Functional notes
// - Host drives clock; data open drain, idles high.
// - Ignore everything until a start is seen.
// - Start is data falling while clock high.
// - Answer to seven-bit strapped bus address.
// - Direction bit one reads, zero writes.
// - Acknowledge when address matches the straps.
// - Recognise stop and repeated start.
// - Host holds data stable while clock high.
// - Sample write data on delayed rising clock.
// - Deglitch and delay clock by 120 ns.
// - Change read data after delayed falling clock.
// - Write: address, register byte, data, stop.
// - First write byte loads register pointer.
// - Pointer advances after each written byte.
// - Reads return consecutive registers from pointer.
// - Port keeps working during shutdown.
// - Shutdown held low during power-on.
`timescale 1ns/10ps
module serial_config_slave (
    serial_config_if.device bus,
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [serial_config_pkg::BUS_ADDR_W-1:0] busAddressStraps,
    input wire logic shutdownInput,
    input wire logic [serial_config_pkg::BYTE_W-1:0] cfgRdData,
    output logic [serial_config_pkg::BYTE_W-1:0] cfgRdAddr,
    output logic cfgWrStb,
    output logic [serial_config_pkg::BYTE_W-1:0] cfgWrAddr,
    output logic [serial_config_pkg::BYTE_W-1:0] cfgWrData,
    output logic shutdownActive
);
    serial_config_pkg::slave_state_t state;
    logic sclLevel;
    logic sclRise;
    logic sclFall;
    logic sdaLevel;
    logic sdaRise;
    logic sdaFall;
    logic [3:0] bitCnt;
    logic [serial_config_pkg::BYTE_W-1:0] rxShift;
    logic [serial_config_pkg::BYTE_W-1:0] txShift;
    logic rw;
    logic hostAck;
    logic sdaOe;
    logic sdaOut;
    logic [serial_config_pkg::BUS_ADDR_W-1:0] strapSyncA;
    logic [serial_config_pkg::BUS_ADDR_W-1:0] strapSync;
    logic shutdownSyncA;
    logic startSeen;
    logic stopSeen;
    logic rxState;
    logic byteDone;
    logic addrMatch;
    logic ackNow;
    logic loadRead;
    logic writeNow;

    function automatic logic isRxState(input serial_config_pkg::slave_state_t s);
        return (s == serial_config_pkg::ST_ADDR) || (s == serial_config_pkg::ST_REG) ||
            (s == serial_config_pkg::ST_WDATA);
    endfunction

    function automatic logic [3:0] bump(input logic [3:0] v);
        return v + 4'h1;
    endfunction

    line_deglitch sclFilter (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .lineIn(bus.scl),
        .level(sclLevel),
        .rise(sclRise),
        .fall(sclFall)
    );

    // Data gets the same delay so start and stop keep their order to the clock.
    line_deglitch sdaFilter (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .lineIn(bus.sda),
        .level(sdaLevel),
        .rise(sdaRise),
        .fall(sdaFall)
    );

    // Straps and shutdown are pins, so both pass two flip-flops.
    // shutdown never gates port
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strapSyncA <= '0;
            strapSync <= '0;
            shutdownSyncA <= 1'b0;
            shutdownActive <= 1'b0;
        end else begin
            strapSyncA <= busAddressStraps;
            strapSync <= strapSyncA;
            shutdownSyncA <= shutdownInput;
            shutdownActive <= shutdownSyncA;
        end
    end

    assign startSeen = sdaFall && sclLevel;
    assign stopSeen = sdaRise && sclLevel;
    assign rxState = isRxState(state);
    assign byteDone = sclFall && rxState && (bitCnt == serial_config_pkg::BITS_PER_BYTE);
    assign addrMatch = rxShift[serial_config_pkg::BYTE_W-1:1] == strapSync;
    assign ackNow = byteDone && ((state != serial_config_pkg::ST_ADDR) || addrMatch);
    assign loadRead = sclFall && (((state == serial_config_pkg::ST_ADDR_ACK) &&
        (rw == serial_config_pkg::DIR_READ)) ||
        ((state == serial_config_pkg::ST_RDATA_ACK) && hostAck));
    assign writeNow = byteDone && (state == serial_config_pkg::ST_WDATA);

    // Protocol sequencing and bit shifting.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= serial_config_pkg::ST_IDLE;
            bitCnt <= '0;
            rxShift <= '0;
            txShift <= '0;
            rw <= serial_config_pkg::DIR_WRITE;
            hostAck <= 1'b0;
        end else if (startSeen) begin
            state <= serial_config_pkg::ST_ADDR;
            bitCnt <= '0;
        end else if (stopSeen) begin
            state <= serial_config_pkg::ST_IDLE;
        end else if (sclRise) begin
            if (rxState) begin
                rxShift <= {rxShift[serial_config_pkg::BYTE_W-2:0], sdaLevel};
                bitCnt <= bump(bitCnt);
            end
            if (state == serial_config_pkg::ST_RDATA_ACK) begin
                hostAck <= !sdaLevel;
            end
        end else if (sclFall) begin
            case (state)
                serial_config_pkg::ST_IDLE: begin
                    state <= serial_config_pkg::ST_IDLE;
                end
                serial_config_pkg::ST_ADDR: begin
                    if (byteDone) begin
                        rw <= rxShift[0];
                        state <= addrMatch ? serial_config_pkg::ST_ADDR_ACK :
                            serial_config_pkg::ST_IDLE;
                    end
                end
                serial_config_pkg::ST_REG: begin
                    if (byteDone) begin
                        state <= serial_config_pkg::ST_REG_ACK;
                    end
                end
                serial_config_pkg::ST_WDATA: begin
                    if (byteDone) begin
                        state <= serial_config_pkg::ST_WDATA_ACK;
                    end
                end
                serial_config_pkg::ST_ADDR_ACK: begin
                    bitCnt <= '0;
                    state <= serial_config_pkg::ST_REG;
                    if (loadRead) begin
                        txShift <= cfgRdData;
                        bitCnt <= 4'h1;
                        state <= serial_config_pkg::ST_RDATA;
                    end
                end
                serial_config_pkg::ST_REG_ACK, serial_config_pkg::ST_WDATA_ACK: begin
                    bitCnt <= '0;
                    state <= serial_config_pkg::ST_WDATA;
                end
                serial_config_pkg::ST_RDATA: begin
                    if (bitCnt == serial_config_pkg::BITS_PER_BYTE) begin
                        state <= serial_config_pkg::ST_RDATA_ACK;
                    end else begin
                        txShift <= {txShift[serial_config_pkg::BYTE_W-2:0], 1'b0};
                        bitCnt <= bump(bitCnt);
                    end
                end
                serial_config_pkg::ST_RDATA_ACK: begin
                    if (loadRead) begin
                        txShift <= cfgRdData;
                        bitCnt <= 4'h1;
                        state <= serial_config_pkg::ST_RDATA;
                    end else begin
                        state <= serial_config_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= serial_config_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Data line drive; it only moves on start, stop or a delayed falling clock.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
        end else if (startSeen || stopSeen) begin
            sdaOe <= 1'b0;
        end else if (sclFall) begin
            if (loadRead) begin
                sdaOe <= !cfgRdData[serial_config_pkg::BYTE_W-1];
            end else if (ackNow) begin
                sdaOe <= 1'b1;
            end else if ((state == serial_config_pkg::ST_RDATA) &&
                (bitCnt != serial_config_pkg::BITS_PER_BYTE)) begin
                sdaOe <= !txShift[serial_config_pkg::BYTE_W-2];
            end else begin
                sdaOe <= 1'b0;
            end
        end
    end

    assign bus.devSdaOe = sdaOe;
    assign bus.devSdaOut = sdaOut;

    // Register pointer; read loads take the current value then step past it.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgRdAddr <= '0;
        end else if (byteDone && (state == serial_config_pkg::ST_REG)) begin
            cfgRdAddr <= rxShift;
        end else if (writeNow || loadRead) begin
            cfgRdAddr <= cfgRdAddr + 8'h01;
        end
    end

    // The write address is latched apart from the pointer, which moves on at once.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgWrStb <= 1'b0;
            cfgWrAddr <= '0;
            cfgWrData <= '0;
        end else begin
            cfgWrStb <= writeNow;
            if (writeNow) begin
                cfgWrAddr <= cfgRdAddr;
                cfgWrData <= rxShift;
            end
        end
    end

endmodule // serial_config_slave

// file: src/serial_config_host.sv
// Host controller end of the two-wire configuration port.
`timescale 1ns/10ps
module serial_config_host (
    serial_config_if.host bus,
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic cmdValid,
    input wire logic cmdRead,
    input wire logic [serial_config_pkg::BUS_ADDR_W-1:0] cmdDevAddr,
    input wire logic [serial_config_pkg::BYTE_W-1:0] cmdRegAddr,
    input wire logic [serial_config_pkg::BYTE_W-1:0] cmdWrData,
    output logic cmdReady,
    output logic [serial_config_pkg::BYTE_W-1:0] rdData,
    output logic rdValid,
    output logic ackError
);
    logic busy;
    logic rdMode;
    logic [serial_config_pkg::BUS_ADDR_W-1:0] devAddr;
    logic [serial_config_pkg::BYTE_W-1:0] regAddr;
    logic [serial_config_pkg::BYTE_W-1:0] wrData;
    logic [serial_config_pkg::QCNT_W-1:0] qCnt;
    logic [1:0] quarter;
    logic [2:0] stepIdx;
    logic [3:0] bitIdx;
    logic [serial_config_pkg::BYTE_W-1:0] rdShift;
    logic sdaSyncA;
    logic sdaSync;
    logic sclReg;
    logic sdaOeReg;
    logic next_scl;
    logic next_oe;
    logic tick;
    logic rxByte;
    serial_config_pkg::step_kind_t kind;
    logic [serial_config_pkg::BYTE_W-1:0] txByte;

    function automatic serial_config_pkg::step_kind_t stepKind(input logic rd,
        input logic [2:0] idx);
        serial_config_pkg::step_kind_t k;
        k = serial_config_pkg::STEP_BYTE;
        if (idx == 3'h0 || (rd && idx == serial_config_pkg::STEP_DATA_OR_RESTART)) begin
            k = serial_config_pkg::STEP_START;
        end else if ((rd && idx == serial_config_pkg::STEP_RD_STOP) ||
            (!rd && idx == serial_config_pkg::STEP_WR_STOP)) begin
            k = serial_config_pkg::STEP_STOP;
        end else if ((rd && idx > serial_config_pkg::STEP_RD_STOP) ||
            (!rd && idx > serial_config_pkg::STEP_WR_STOP)) begin
            k = serial_config_pkg::STEP_DONE;
        end
        return k;
    endfunction

    assign kind = stepKind(rdMode, stepIdx);
    assign rxByte = rdMode && (stepIdx == serial_config_pkg::STEP_RX);
    assign tick = busy && (qCnt == serial_config_pkg::QUARTER_LAST);

    always_comb begin
        case (stepIdx)
            serial_config_pkg::STEP_DEV_W: txByte = {devAddr, serial_config_pkg::DIR_WRITE};
            serial_config_pkg::STEP_REG: txByte = regAddr;
            serial_config_pkg::STEP_DEV_R: txByte = {devAddr, serial_config_pkg::DIR_READ};
            default: txByte = wrData;
        endcase
    end

    // byte data moves only while clock low; start and stop move it with clock high
    always_comb begin
        next_scl = (quarter == 2'h1) || (quarter == 2'h2);
        next_oe = 1'b0;
        case (kind)
            serial_config_pkg::STEP_START: next_oe = quarter[1];
            serial_config_pkg::STEP_BYTE: next_oe = !rxByte &&
                (bitIdx != serial_config_pkg::BITS_PER_BYTE) && !txByte[3'h7 - bitIdx[2:0]];
            serial_config_pkg::STEP_STOP: begin
                next_scl = quarter != 2'h0;
                next_oe = !quarter[1];
            end
            default: next_scl = 1'b1;
        endcase
        if (!busy) begin
            next_scl = 1'b1;
            next_oe = 1'b0;
        end
    end

    // host makes the clock by dividing its own
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclReg <= 1'b1;
            sdaOeReg <= 1'b0;
            sdaSyncA <= 1'b1;
            sdaSync <= 1'b1;
        end else begin
            sclReg <= next_scl;
            sdaOeReg <= next_oe;
            sdaSyncA <= bus.sda;
            sdaSync <= sdaSyncA;
        end
    end

    assign bus.scl = sclReg;
    assign bus.hostSdaOe = sdaOeReg;
    assign bus.hostSdaOut = 1'b0;

    // Command acceptance, step walk and result capture.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            cmdReady <= 1'b1;
            rdMode <= 1'b0;
            devAddr <= '0;
            regAddr <= '0;
            wrData <= '0;
            qCnt <= '0;
            quarter <= '0;
            stepIdx <= '0;
            bitIdx <= '0;
            rdShift <= '0;
            rdData <= '0;
            rdValid <= 1'b0;
            ackError <= 1'b0;
        end else begin
            rdValid <= 1'b0;
            if (!busy) begin
                if (cmdValid) begin
                    busy <= 1'b1;
                    cmdReady <= 1'b0;
                    rdMode <= cmdRead;
                    devAddr <= cmdDevAddr;
                    regAddr <= cmdRegAddr;
                    wrData <= cmdWrData;
                    qCnt <= '0;
                    quarter <= '0;
                    stepIdx <= '0;
                    bitIdx <= '0;
                    ackError <= 1'b0;
                end
            end else if (kind == serial_config_pkg::STEP_DONE) begin
                busy <= 1'b0;
                cmdReady <= 1'b1;
                rdValid <= rdMode;
                rdData <= rdShift;
            end else begin
                qCnt <= tick ? '0 : qCnt + 1'b1;
                if (tick) begin
                    quarter <= quarter + 2'h1;
                end
                if (tick && quarter == serial_config_pkg::SAMPLE_QUARTER &&
                    kind == serial_config_pkg::STEP_BYTE) begin
                    if (rxByte && bitIdx != serial_config_pkg::BITS_PER_BYTE) begin
                        rdShift <= {rdShift[serial_config_pkg::BYTE_W-2:0], sdaSync};
                    end else if (!rxByte && bitIdx == serial_config_pkg::BITS_PER_BYTE) begin
                        ackError <= ackError | sdaSync;
                    end
                end
                if (tick && quarter == serial_config_pkg::LAST_QUARTER) begin
                    if (kind == serial_config_pkg::STEP_BYTE &&
                        bitIdx != serial_config_pkg::BITS_PER_BYTE) begin
                        bitIdx <= bitIdx + 4'h1;
                    end else begin
                        bitIdx <= '0;
                        stepIdx <= stepIdx + 3'h1;
                    end
                end
            end
        end
    end
endmodule // serial_config_host

// file: test/serial_config_checker.sv
// Bus-level assertions for the two-wire configuration port.
`timescale 1ns/10ps
module serial_config_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda,
    input wire logic hostSdaOe,
    input wire logic hostSdaOut,
    input wire logic devSdaOe,
    input wire logic devSdaOut
);
    logic started;
    logic prevSda;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // A frame runs from start to stop; the device may pull data only inside one.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prevSda <= 1'b1;
            started <= 1'b0;
        end else begin
            prevSda <= sda;
            if (scl && prevSda && !sda) begin
                started <= 1'b1;
            end else if (scl && !prevSda && sda) begin
                started <= 1'b0;
            end
        end
    end
    chk_dev_pull_only: assert property (devSdaOe |-> !devSdaOut)
        else $error("device drives data high");
    chk_host_pull_only: assert property (hostSdaOe |-> !hostSdaOut)
        else $error("host drives data high");
    chk_quiet_before_start: assert property (devSdaOe |-> started)
        else $error("device drives outside a frame");
    chk_change_scl_low: assert property ($changed(devSdaOe) |-> !scl)
        else $error("device data changed with clock high");
    chk_change_delayed: assert property ($changed(devSdaOe) |-> !$past(scl, 30))
        else $error("device data changed before the filter delay");
    chk_setup_margin: assert property ($changed(devSdaOe) |=> !scl [*8])
        else $error("device data changed too near a clock rise");
    chk_ack_held: assert property ($rose(devSdaOe) |-> devSdaOe [*8])
        else $error("device pull too short");
    chk_stop_released: assert property (scl && $rose(sda) |-> !devSdaOe)
        else $error("device holds data at stop");
endmodule // serial_config_checker

// file: test/serial_config_slave_test.sv
// Self-checking bench joining the host controller and the configuration slave.
`timescale 1ns/10ps
`define CHECK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin errors++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, ac); end end
module serial_config_slave_test;
    localparam logic [6:0] STRAPS = 7'h4b;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdRead = 1'b0;
    logic shutdownInput = 1'b0;
    logic [6:0] straps = STRAPS;
    logic [6:0] cmdDevAddr = 7'h00;
    logic [7:0] cmdRegAddr = 8'h00;
    logic [7:0] cmdWrData = 8'h00;
    logic [7:0] cfgRdData, cfgRdAddr, cfgWrAddr, cfgWrData, rdData;
    logic cfgWrStb, cmdReady, rdValid, ackError, shutdownActive;
    logic [7:0] regs [256];
    int errors = 0;
    int num_checks = 0;
    int wrCount = 0;
    serial_config_if bif();
    // The register store is ours, read combinationally at the pointer.
    assign cfgRdData = regs[cfgRdAddr];
    serial_config_slave u_serial_config_slave(.bus(bif), .sys_clk(sys_clk), .rst_b(rst_b),
        .busAddressStraps(straps), .shutdownInput(shutdownInput), .cfgRdData(cfgRdData),
        .cfgRdAddr(cfgRdAddr), .cfgWrStb(cfgWrStb), .cfgWrAddr(cfgWrAddr),
        .cfgWrData(cfgWrData), .shutdownActive(shutdownActive));
    serial_config_host u_serial_config_host(.bus(bif), .sys_clk(sys_clk), .rst_b(rst_b),
        .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdDevAddr(cmdDevAddr),
        .cmdRegAddr(cmdRegAddr), .cmdWrData(cmdWrData), .cmdReady(cmdReady),
        .rdData(rdData), .rdValid(rdValid), .ackError(ackError));
    serial_config_checker u_serial_config_checker(.sys_clk(sys_clk), .rst_b(rst_b),
        .scl(bif.scl), .sda(bif.sda), .hostSdaOe(bif.hostSdaOe),
        .hostSdaOut(bif.hostSdaOut), .devSdaOe(bif.devSdaOe), .devSdaOut(bif.devSdaOut));
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (cfgWrStb === 1'b1) begin
            regs[cfgWrAddr] <= cfgWrData;
            wrCount <= wrCount + 1;
        end
    end
    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // A bus slot is 400 cycles and a read 39 slots, so 20000 cycles bound any command.
    task automatic run_cmd(input logic rd, input logic [6:0] dev, input logic [7:0] ra,
            input logic [7:0] wd);
        int n = 0;
        @(posedge sys_clk);
        cmdValid <= 1'b1;
        cmdRead <= rd;
        cmdDevAddr <= dev;
        cmdRegAddr <= ra;
        cmdWrData <= wd;
        @(posedge sys_clk);
        cmdValid <= 1'b0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (cmdReady !== 1'b1 && n < 20000);
        `CHECK("command done", 1'b1, cmdReady)
        `CHECK("read valid pulse", rd, rdValid)
        if (cmdReady !== 1'b1) begin
            report_and_stop();
        end
        @(posedge sys_clk);
    endtask
    task automatic test_write();
        shutdownInput <= 1'b1;
        run_cmd(1'b0, STRAPS, 8'h1b, 8'ha5);
        `CHECK("write count", 1, wrCount)
        `CHECK("write address", 8'h1b, cfgWrAddr)
        `CHECK("write data", 8'ha5, cfgWrData)
        `CHECK("pointer after write", 8'h1c, cfgRdAddr)
        `CHECK("write ack", 1'b0, ackError)
        `CHECK("shutdown seen", 1'b1, shutdownActive)
    endtask
    task automatic test_read();
        run_cmd(1'b1, STRAPS, 8'h1b, 8'h00);
        `CHECK("read data", 8'ha5, rdData)
        `CHECK("pointer after read", 8'h1c, cfgRdAddr)
        `CHECK("read ack", 1'b0, ackError)
        `CHECK("read writes nothing", 1, wrCount)
    endtask
    task automatic test_mismatch();
        shutdownInput <= 1'b0;
        run_cmd(1'b0, STRAPS ^ 7'h01, 8'h10, 8'h77);
        `CHECK("foreign address nack", 1'b1, ackError)
        `CHECK("foreign write ignored", 1, wrCount)
        `CHECK("pointer kept", 8'h1c, cfgRdAddr)
        // The straps are pins: moving them moves the address the port answers to.
        straps <= STRAPS ^ 7'h01;
        run_cmd(1'b0, STRAPS ^ 7'h01, 8'h10, 8'h77);
        `CHECK("new strap ack", 1'b0, ackError)
        `CHECK("new strap write", 8'h77, cfgWrData)
        `CHECK("new strap address", 8'h10, cfgWrAddr)
    endtask
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i) ^ 8'h3c;
        end
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        // Lines must idle past the deglitch window before the first start.
        repeat (40) @(posedge sys_clk);
        test_write();
        test_read();
        test_mismatch();
        report_and_stop();
    end
endmodule // serial_config_slave_test
